//--- hw/park_seq_pkg.sv
// constants and types for the power and park sequencer
// What this block and the system around it must do
// [R1] normal park finishes within 20ms of request fall
// [R2] reset voltage regulation stops 12ms after park
// [R3] low fast park request runs fast park
// [R4] host keeps clock, reset 32us after request
// [R5] fast park request 32us before supplies fail
// [R6] fast park request high before reset release
// [R7] reset held until supplies, clocks stable
// [R8] flash and general pins tristated during reset
// [R9] lamp selects and mirror enable low in reset
// [R10] all I/Os active once reset released
// [R11] init waits PLL lock, then flash load
// [R12] busy flag high immediately after reset release
// [R13] busy flag low when initialization completes
// [R14] host keeps power request until busy clears
// [R15] host waits busy clear before bus traffic
// [R16] fast park input filtered against 150ns glitches
// [R17] power request fall runs long normal park
// [R18] supplies and reset held during normal park
// [R19] fast park only when power loss imminent
// [R20] reset held 5ms after supplies good
// [R21] power request high runs display, low shuts
// [R22] inputs synchronised; fast park beats normal park
// [R23] busy flag held low during reset
package park_seq_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned NORMAL_PARK_MS  = 20;
  localparam int unsigned REG_STOP_MS     = 12;
  localparam int unsigned FAST_PARK_US    = 32;
  localparam int unsigned GLITCH_NS       = 150;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  // longest times round down
  localparam int unsigned NORMAL_PARK_CYC = NORMAL_PARK_MS * (CLK_HZ / 1000);
  localparam int unsigned REG_STOP_CYC    = REG_STOP_MS * (CLK_HZ / 1000);
  localparam int unsigned FAST_PARK_CYC   = FAST_PARK_US * (CLK_HZ / 1_000_000);
  // glitch filter must outlast the glitch: round up, plus one
  localparam int unsigned FILTER_CYC      = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int          CNT_W           = 22;
  localparam int          GPIO_W          = 20;
  localparam logic        INPUT_RESET_VAL = 1'b0;

  typedef enum logic [2:0] {
    ST_PLL_WAIT,
    ST_FLASH_LOAD,
    ST_RUN,
    ST_NORMAL_PARK,
    ST_FAST_PARK,
    ST_REG_HOLD,
    ST_OFF
  } seq_state_t;
endpackage

//--- hw/pin_sync_filter.sv
// three-stage synchroniser with optional stability filter
`timescale 1ns/1ps
module pin_sync_filter #(
  parameter int unsigned STABLE_CYC = 1,
  parameter logic        RESET_VAL  = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // pin and clean level
  input  wire logic pin_in,
  output logic      level_out
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       level_reg;
  logic       level_next;

  // change counts only once stage two and three agree for STABLE_CYC cycles
  always_comb begin
    sync_next  = {sync_reg[1:0], pin_in};
    cnt_next   = cnt_reg;
    level_next = level_reg;
    if (sync_reg[1] == sync_reg[2] && sync_reg[2] != level_reg) begin
      if (cnt_reg >= 8'(STABLE_CYC - 1)) begin
        level_next = sync_reg[2];
        cnt_next   = 8'h00;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end else begin
      cnt_next = 8'h00;                            // glitch restarts the wait
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg  <= {3{RESET_VAL}};
      cnt_reg   <= 8'h00;
      level_reg <= RESET_VAL;
    end else begin
      sync_reg  <= sync_next;
      cnt_reg   <= cnt_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule // pin_sync_filter

//--- hw/power_park_sequencer.sv
// reset, start-up and park sequencer top
`timescale 1ns/1ps
module power_park_sequencer #(
  parameter int unsigned NORMAL_PARK_CYC = park_seq_pkg::NORMAL_PARK_CYC,
  parameter int unsigned REG_STOP_CYC    = park_seq_pkg::REG_STOP_CYC
) (
  // clock and reset (reset is the system reset pin)
  input  wire logic                              sys_clk,
  input  wire logic                              arst_n,
  // control pins from host and power monitor
  input  wire logic                              power_request,
  input  wire logic                              fast_park_request_n,
  // status from internal blocks
  input  wire logic                              pll_locked,
  input  wire logic                              flash_load_done,
  input  wire logic                              park_done,
  // flash serial pins, enables high while driven
  input  wire logic                              flash_serial_clock_int,
  input  wire logic                              flash_serial_out_int,
  input  wire logic                              flash_select0_n_int,
  input  wire logic                              flash_select1_n_int,
  output logic                                   flash_serial_clock,
  output logic                                   flash_serial_out,
  output logic                                   flash_select0_n,
  output logic                                   flash_select1_n,
  output logic                                   flash_oe,
  // general pins
  input  wire logic [park_seq_pkg::GPIO_W-1:0]   general_pins_int,
  input  wire logic [park_seq_pkg::GPIO_W-1:0]   general_pins_oe_int,
  output logic      [park_seq_pkg::GPIO_W-1:0]   general_pins_out,
  output logic      [park_seq_pkg::GPIO_W-1:0]   general_pins_oe,
  // lamp and mirror control
  input  wire logic                              lamp_select_0_int,
  input  wire logic                              lamp_select_1_int,
  output logic                                   lamp_select_0,
  output logic                                   lamp_select_1,
  output logic                                   mirror_drive_enable_n,
  // sequencing status
  output logic                                   init_busy_flag,
  output logic                                   init_busy_oe,
  output logic                                   flash_load_start,
  output logic                                   normal_park_active,
  output logic                                   fast_park_active,
  output logic                                   reset_reg_enable,
  output logic                                   display_enable
);
  logic                               power_req_s;
  logic                               park_n_s;
  park_seq_pkg::seq_state_t           state_reg;
  park_seq_pkg::seq_state_t           state_next;
  logic [park_seq_pkg::CNT_W-1:0]     cnt_reg;
  logic [park_seq_pkg::CNT_W-1:0]     cnt_next;
  logic                               live_reg;
  logic                               fspi_clk_reg, fspi_out_reg, fsel0_reg, fsel1_reg, foe_reg;
  logic [park_seq_pkg::GPIO_W-1:0]    gp_out_reg, gp_oe_reg;
  logic                               lamp0_reg, lamp1_reg, mden_reg;
  logic                               busy_reg, busy_oe_reg, fl_start_reg;
  logic                               np_reg, fp_reg, rreg_reg, disp_reg;
  logic                               fspi_clk_next, fspi_out_next, fsel0_next, fsel1_next;
  logic [park_seq_pkg::GPIO_W-1:0]    gp_out_next, gp_oe_next;
  logic                               lamp0_next, lamp1_next, mden_next, busy_next;
  logic                               fl_start_next, np_next, fp_next, rreg_next, disp_next;

  // input sync; power request needs no glitch filter
  pin_sync_filter #(
    .STABLE_CYC (1),
    .RESET_VAL  (park_seq_pkg::INPUT_RESET_VAL)
  ) u_power_sync (                                 // [R22]
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .pin_in    (power_request),
    .level_out (power_req_s)
  );

  // fast park pin must stay stable beyond a slow-edge glitch
  pin_sync_filter #(
    .STABLE_CYC (park_seq_pkg::FILTER_CYC),
    .RESET_VAL  (1'b1)
  ) u_park_sync (                                  // [R16] [R22]
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .pin_in    (fast_park_request_n),
    .level_out (park_n_s)
  );

  // sequencing state machine
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      park_seq_pkg::ST_PLL_WAIT: begin
        if (pll_locked) begin
          state_next = park_seq_pkg::ST_FLASH_LOAD;  // [R11]
        end
      end
      park_seq_pkg::ST_FLASH_LOAD: begin
        if (flash_load_done) begin
          state_next = park_seq_pkg::ST_RUN;         // [R11] [R13]
        end
      end
      park_seq_pkg::ST_RUN: begin
        if (!power_req_s) begin
          state_next = park_seq_pkg::ST_NORMAL_PARK; // [R1] [R17] [R21]
          cnt_next   = '0;
        end
      end
      park_seq_pkg::ST_NORMAL_PARK: begin
        cnt_next = cnt_reg + 1'b1;
        // park is cut off at the deadline even if the engine lags
        if (park_done || cnt_reg >= park_seq_pkg::CNT_W'(NORMAL_PARK_CYC - 1)) begin
          state_next = park_seq_pkg::ST_REG_HOLD;    // [R1]
          cnt_next   = '0;
        end
      end
      park_seq_pkg::ST_FAST_PARK: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= park_seq_pkg::CNT_W'(park_seq_pkg::FAST_PARK_CYC - 1)) begin
          state_next = park_seq_pkg::ST_OFF;         // [R3]
        end
      end
      park_seq_pkg::ST_REG_HOLD: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= park_seq_pkg::CNT_W'(REG_STOP_CYC - 1)) begin
          state_next = park_seq_pkg::ST_OFF;         // [R2]
        end
      end
      park_seq_pkg::ST_OFF: begin
        // restart only while power request is high and fast park request released
        if (power_req_s && park_n_s) begin
          state_next = park_seq_pkg::ST_PLL_WAIT;
        end
      end
    endcase
    // fast park overrides any other activity
    if (!park_n_s && state_reg != park_seq_pkg::ST_FAST_PARK
        && state_reg != park_seq_pkg::ST_OFF) begin
      state_next = park_seq_pkg::ST_FAST_PARK;       // [R3] [R22]
      cnt_next   = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= park_seq_pkg::ST_PLL_WAIT;
      cnt_reg   <= '0;
      live_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      live_reg  <= 1'b1;
    end
  end

  // pin stage next values; gated on the next state so pins move with it
  always_comb begin
    fspi_clk_next = flash_serial_clock_int;          // [R10]
    fspi_out_next = flash_serial_out_int;
    fsel0_next    = flash_select0_n_int;
    fsel1_next    = flash_select1_n_int;
    gp_out_next   = general_pins_int;
    gp_oe_next    = general_pins_oe_int;
    lamp0_next    = lamp_select_0_int && state_next == park_seq_pkg::ST_RUN;
    lamp1_next    = lamp_select_1_int && state_next == park_seq_pkg::ST_RUN;
    mden_next     = state_next != park_seq_pkg::ST_OFF;
    busy_next     = state_next == park_seq_pkg::ST_PLL_WAIT
                    || state_next == park_seq_pkg::ST_FLASH_LOAD;  // [R12] [R13]
    fl_start_next = state_reg == park_seq_pkg::ST_PLL_WAIT
                    && state_next == park_seq_pkg::ST_FLASH_LOAD;
    np_next       = state_next == park_seq_pkg::ST_NORMAL_PARK;
    fp_next       = state_next == park_seq_pkg::ST_FAST_PARK;
    // regulation waits one edge after release, kept inside the flop for a clean pin
    rreg_next     = live_reg && state_next != park_seq_pkg::ST_OFF;  // [R2]
    disp_next     = state_next == park_seq_pkg::ST_RUN;              // [R21]
  end

  // registered pin stage; everything inactive or tristated while in reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fspi_clk_reg <= 1'b0;                          // [R8]
      fspi_out_reg <= 1'b0;
      fsel0_reg    <= 1'b0;
      fsel1_reg    <= 1'b0;
      foe_reg      <= 1'b0;
      gp_out_reg   <= '0;
      gp_oe_reg    <= '0;                            // [R8]
      lamp0_reg    <= 1'b0;                          // [R9]
      lamp1_reg    <= 1'b0;
      mden_reg     <= 1'b0;                          // [R9]
      busy_reg     <= 1'b0;                          // [R23]
      busy_oe_reg  <= 1'b0;
      fl_start_reg <= 1'b0;
      np_reg       <= 1'b0;
      fp_reg       <= 1'b0;
      rreg_reg     <= 1'b0;
      disp_reg     <= 1'b0;
    end else begin
      // I/Os go live from the first edge after release
      fspi_clk_reg <= fspi_clk_next;                 // [R10]
      fspi_out_reg <= fspi_out_next;
      fsel0_reg    <= fsel0_next;
      fsel1_reg    <= fsel1_next;
      foe_reg      <= 1'b1;
      gp_out_reg   <= gp_out_next;
      gp_oe_reg    <= gp_oe_next;
      lamp0_reg    <= lamp0_next;
      lamp1_reg    <= lamp1_next;
      mden_reg     <= mden_next;
      busy_reg     <= busy_next;                     // [R12] [R13]
      busy_oe_reg  <= 1'b1;                          // [R12]
      fl_start_reg <= fl_start_next;
      np_reg       <= np_next;
      fp_reg       <= fp_next;
      rreg_reg     <= rreg_next;                     // [R2]
      disp_reg     <= disp_next;                     // [R21]
    end
  end

  assign flash_serial_clock    = fspi_clk_reg;
  assign flash_serial_out      = fspi_out_reg;
  assign flash_select0_n       = fsel0_reg;
  assign flash_select1_n       = fsel1_reg;
  assign flash_oe              = foe_reg;
  assign general_pins_out      = gp_out_reg;
  assign general_pins_oe       = gp_oe_reg;
  assign lamp_select_0         = lamp0_reg;
  assign lamp_select_1         = lamp1_reg;
  assign mirror_drive_enable_n = mden_reg;
  assign init_busy_flag        = busy_reg;
  assign init_busy_oe          = busy_oe_reg;
  assign flash_load_start      = fl_start_reg;
  assign normal_park_active    = np_reg;
  assign fast_park_active      = fp_reg;
  assign reset_reg_enable      = rreg_reg;
  assign display_enable        = disp_reg;
endmodule // power_park_sequencer

//--- test/park_seq_sva.sv
// assertion checker for the power and park sequencer
`timescale 1ns/1ps
module park_seq_sva #(
  parameter int unsigned NORMAL_PARK_CYC = 100,
  parameter int unsigned REG_STOP_CYC    = 50
) (
  // clock, reset and pins
  input wire logic sys_clk, arst_n, power_request, fast_park_request_n, pll_locked,
  input wire logic flash_load_done, flash_oe, lamp_select_0, mirror_drive_enable_n,
  // sequencing status
  input wire logic init_busy_flag, init_busy_oe, flash_load_start, normal_park_active,
  input wire logic fast_park_active, reset_reg_enable, display_enable
);
  logic [21:0] low_cnt, park_cnt, hold_cnt;
  // run lengths; 22 bits never wrap within a run
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt  <= '0;
      park_cnt <= '0;
      hold_cnt <= '0;
    end else begin
      low_cnt  <= fast_park_request_n ? '0 : low_cnt + 22'h00_0001;
      park_cnt <= normal_park_active ? park_cnt + 22'h00_0001 : '0;
      hold_cnt <= (reset_reg_enable && !display_enable && !init_busy_flag &&
                   !normal_park_active && !fast_park_active) ? hold_cnt + 22'h00_0001 : '0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // second edge after release sees the first registered values
  sequence s_released; $past(arst_n) && !$past(arst_n, 2); endsequence
  // run lasts five samples after the pin falls: three sync stages, filter, state
  sequence s_stop_held; (display_enable && !power_request)[*5]; endsequence
  a_release_drive: assert property (s_released |-> init_busy_flag && init_busy_oe &&
    flash_oe && mirror_drive_enable_n) else $error("outputs idle after release");
  a_busy_cause: assert property ($fell(init_busy_flag) |-> $past(flash_load_done) ||
    fast_park_active) else $error("busy dropped without load done");
  a_load_order: assert property (flash_load_start |-> $past(pll_locked) && init_busy_flag)
    else $error("flash load began before lock");
  a_park_excl: assert property (fast_park_active |-> !normal_park_active &&
    !display_enable && !lamp_select_0) else $error("fast park overlaps other state");
  a_glitch_filt: assert property ($rose(fast_park_active) |-> low_cnt >= 22'h00_0010)
    else $error("fast park on a short pulse");
  a_park_bound: assert property (park_cnt <= NORMAL_PARK_CYC + 1)
    else $error("normal park overran");
  a_reg_hold: assert property (hold_cnt <= REG_STOP_CYC + 1)
    else $error("regulation held too long");
  a_park_start: assert property (s_stop_held |=> normal_park_active || fast_park_active)
    else $error("no park after request fell");
endmodule // park_seq_sva

bind power_park_sequencer park_seq_sva #(.NORMAL_PARK_CYC(NORMAL_PARK_CYC),
  .REG_STOP_CYC(REG_STOP_CYC)) u_park_seq_sva (.sys_clk, .arst_n, .power_request,
  .fast_park_request_n, .pll_locked, .flash_load_done, .flash_oe, .lamp_select_0,
  .mirror_drive_enable_n, .init_busy_flag, .init_busy_oe, .flash_load_start,
  .normal_park_active, .fast_park_active, .reset_reg_enable, .display_enable);

//--- test/park_partner_model.sv
// far-side model: pll lock, flash loader and park engine answers
`timescale 1ns/1ps
module park_partner_model (
  // clock, reset, requests and answer delay
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       flash_load_start,
  input  wire logic       normal_park_active,
  input  wire logic [7:0] dly,
  // answers
  output logic            pll_locked,
  output logic            flash_load_done,
  output logic            park_done
);
  logic [7:0] lock_cnt, load_cnt, park_cnt;
  logic       loading;
  // dly 8'hff keeps the park engine silent so the timeout must end the park
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {lock_cnt, load_cnt, park_cnt, loading} <= '0;
      {pll_locked, flash_load_done, park_done} <= '0;
    end else begin
      lock_cnt        <= pll_locked ? lock_cnt : lock_cnt + 8'h01;
      pll_locked      <= pll_locked || lock_cnt == dly;
      loading         <= flash_load_start || (loading && !flash_load_done);
      load_cnt        <= loading ? load_cnt + 8'h01 : 8'h00;
      flash_load_done <= loading && load_cnt == dly && !flash_load_done;
      park_cnt        <= normal_park_active ? park_cnt + 8'h01 : 8'h00;
      park_done       <= normal_park_active && park_cnt == dly && dly != 8'hff;
    end
  end
endmodule // park_partner_model

//--- test/power_park_sequencer_tb.sv
// self-checking bench for the power and park sequencer
`timescale 1ns/1ps
module power_park_sequencer_tb;
  localparam int unsigned NPC = 100;
  localparam int unsigned RSC = 50;
  // stimulus, valued at time zero
  logic        sys_clk = 1'b0, arst_n = 1'b0, power_request = 1'b0, fast_park_request_n = 1'b1;
  logic        flash_serial_clock_int = 1'b0, flash_serial_out_int = 1'b0;
  logic        flash_select0_n_int = 1'b0, flash_select1_n_int = 1'b0;
  logic        lamp_select_0_int = 1'b0, lamp_select_1_int = 1'b0;
  logic [19:0] general_pins_int = '0, general_pins_oe_int = '0;
  logic [7:0]  dly = 8'h03;
  // design and model outputs
  logic        pll_locked, flash_load_done, park_done, flash_serial_clock, flash_serial_out;
  logic        flash_select0_n, flash_select1_n, flash_oe, lamp_select_0, lamp_select_1;
  logic        mirror_drive_enable_n, init_busy_flag, init_busy_oe, flash_load_start;
  logic        normal_park_active, fast_park_active, reset_reg_enable, display_enable;
  logic [19:0] general_pins_out, general_pins_oe;
  int          n_errors = 0, tests_run = 0, i;

  power_park_sequencer #(.NORMAL_PARK_CYC(NPC), .REG_STOP_CYC(RSC)) u_power_park_sequencer (
    .sys_clk, .arst_n, .power_request, .fast_park_request_n, .pll_locked, .flash_load_done,
    .park_done, .flash_serial_clock_int, .flash_serial_out_int, .flash_select0_n_int,
    .flash_select1_n_int, .flash_serial_clock, .flash_serial_out, .flash_select0_n,
    .flash_select1_n, .flash_oe, .general_pins_int, .general_pins_oe_int, .general_pins_out,
    .general_pins_oe, .lamp_select_0_int, .lamp_select_1_int, .lamp_select_0, .lamp_select_1,
    .mirror_drive_enable_n, .init_busy_flag, .init_busy_oe, .flash_load_start,
    .normal_park_active, .fast_park_active, .reset_reg_enable, .display_enable);
  park_partner_model u_park_partner_model (.sys_clk, .arst_n, .flash_load_start,
    .normal_park_active, .dly, .pll_locked, .flash_load_done, .park_done);

  // 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // inputs move 1 ns after the edge so sampling never races
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // a wait that ran out of cycles ends the run
  task automatic hang(input int n);
    if (n == 0) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, 0, 1);
      finish_test();
    end
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    repeat (10) step();
    chk({flash_oe, general_pins_oe, lamp_select_0, lamp_select_1}, '0);
    chk({mirror_drive_enable_n, init_busy_flag, init_busy_oe}, '0);
    fast_park_request_n = 1'b1;
    arst_n = 1'b1;
  endtask
  // start-up, with or without a reset, pin values varied by d
  task automatic t_start(input logic rst, input logic [7:0] d);
    dly = d;
    {flash_serial_clock_int, flash_serial_out_int} = d[3:2];
    {flash_select0_n_int, flash_select1_n_int, lamp_select_0_int, lamp_select_1_int} = d[3:0];
    general_pins_int = 20'h5_a5a5 ^ {20{d[0]}};
    general_pins_oe_int = 20'hf_0f0f ^ {20{d[1]}};
    power_request = 1'b1;
    if (rst) do_reset();
    for (i = 20; i > 0 && init_busy_flag !== 1'b1; i--) step();
    hang(i);
    chk({init_busy_oe, flash_oe, mirror_drive_enable_n}, 3'h7);
    for (i = 3000; i > 0 && init_busy_flag !== 1'b0; i--) step();
    hang(i);
    step();
    chk({display_enable, lamp_select_0, lamp_select_1}, {1'b1, d[1:0]});
    chk({general_pins_out, general_pins_oe}, {general_pins_int, general_pins_oe_int});
    chk({flash_serial_clock, flash_serial_out, flash_select0_n, flash_select1_n},
        {d[3:2], d[3:2]});
  endtask
  // normal park; park engine answers after d cycles or never
  task automatic t_normal(input logic [7:0] d, input int unsigned mx);
    int unsigned pl, hl;
    pl = 0;
    hl = 0;
    dly = d;
    power_request = 1'b0;
    for (i = NPC + RSC + 50; i > 0 && mirror_drive_enable_n !== 1'b0; i--) begin
      step();
      pl += (normal_park_active === 1'b1);
      hl += (reset_reg_enable === 1'b1 && !normal_park_active && !display_enable);
    end
    hang(i);
    chk(pl > 0 && pl <= mx, 1'b1);
    chk(hl + 1 >= RSC && hl <= RSC + 1, 1'b1);
  endtask
  // short spike dropped, then a real fast park overrides a normal park
  task automatic t_fast();
    int unsigned cnt;
    fast_park_request_n = 1'b0;
    repeat (15) step(); // 150 ns spike, the longest that must be ignored
    fast_park_request_n = 1'b1;
    repeat (30) step();
    chk(fast_park_active, 1'b0);
    dly = 8'hff;
    power_request = 1'b0;
    for (i = 50; i > 0 && normal_park_active !== 1'b1; i--) step();
    hang(i);
    fast_park_request_n = 1'b0;
    for (i = 60; i > 0 && fast_park_active !== 1'b1; i--) step();
    hang(i);
    chk(normal_park_active, 1'b0);
    for (cnt = 0; cnt < 4000 && fast_park_active === 1'b1; cnt++) step();
    chk(cnt + 1 >= park_seq_pkg::FAST_PARK_CYC && cnt <= park_seq_pkg::FAST_PARK_CYC + 1,
        1'b1);
    chk({mirror_drive_enable_n, reset_reg_enable}, 2'h0);
  endtask

  initial begin
    t_start(1'b1, 8'h03);
    t_normal(8'h05, 12);
    t_start(1'b0, 8'h2c);
    t_normal(8'hff, NPC + 1);
    t_start(1'b1, 8'h3a);
    t_fast();
    finish_test();
  end
endmodule // power_park_sequencer_tb
